/* File: pkg/spi_ctl_defines.svh */
/*
 Register offsets, field positions, reset values and clock division counts
 of the serial port control block. Definitions only; included by bare name.
*/
`ifndef SPI_CTL_DEFINES_SVH
`define SPI_CTL_DEFINES_SVH

// Register byte offsets
`define OFF_CTRL    8'h00
`define OFF_STATUS  8'h04
`define OFF_DATA    8'h08
`define OFF_PINCFG  8'h0c

// serial_port_control fields
`define CTL_IRQEN   7
`define CTL_EN      6
`define CTL_ORDER   5
`define CTL_MASTER_SELECT    4
`define CTL_CLOCK_IDLE_LEVEL    3
`define CTL_CLOCK_SAMPLE_PHASE    2

// serial_port_status fields
`define STS_DONE    7
`define STS_COLL    6
`define STS_DBL     0

// Pin configuration fields
`define PIN_DIR_MOSI 0
`define PIN_DIR_MISO 1
`define PIN_DIR_SCK  2
`define PIN_DIR_SS   3
`define PIN_SS_VAL   4

// Reset values
`define RST_CTRL    8'h00
`define RST_PINCFG  5'h00

// Half periods of SCK in clock cycles: divisors 4,16,64,128 and 2,8,32,64
`define HALF_DIV4   7'h02
`define HALF_DIV16  7'h08
`define HALF_DIV64  7'h20
`define HALF_DIV128 7'h40
`define HALF_DIV2   7'h01
`define HALF_DIV8   7'h04
`define HALF_DIV32  7'h10

// Index of the last edge and of the last bit in one byte
`define LAST_EDGE   4'hf
`define LAST_BIT    4'h7
`endif

/* File: pkg/spi_ctl_pkg.sv */
/*
 Types of the serial port control block.
 Assumes nothing of its surroundings.
*/
package spi_ctl_pkg;
   typedef enum logic [0:0] {
      MS_IDLE  = 1'b0,
      MS_SHIFT = 1'b1
   } master_state_t;
endpackage

/* File: rtl/pin_sync.sv */
/*
 Three flip-flop input synchroniser with agreement filter.
 Assumes an asynchronous pin level and the block's single clock.
*/
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clock,    // System clock
   input  wire logic sys_rst,  // Async reset, active high
   input  wire logic pinIn,    // Raw pin level
   output logic      levelOut  // Filtered level
);
   logic stage1_r;
   logic stage2_r;
   logic stage3_r;
   logic level_r;
   logic level_nxt;

   // Accept a change once second and third stages agree
   always_comb begin
      level_nxt = (stage2_r == stage3_r) ? stage3_r : level_r;
   end

   // Stage registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stage1_r <= RESET_VAL;
         stage2_r <= RESET_VAL;
         stage3_r <= RESET_VAL;
         level_r  <= RESET_VAL;
      end else begin
         stage1_r <= pinIn;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         level_r  <= level_nxt;
      end
   end

   assign levelOut = level_r;
endmodule

/* File: rtl/sck_divider.sv */
/*
 Serial clock half period timer for master transfers.
 Assumes halfCount is held stable while run is high.
*/
`timescale 1ns/1ps
module sck_divider #(
   parameter int CW = 7
) (
   input  wire logic          clock,     // System clock
   input  wire logic          sys_rst,   // Async reset, active high
   input  wire logic          run,       // Generator running
   input  wire logic [CW-1:0] halfCount, // Cycles per SCK half period
   output logic               tick       // One pulse per half period
);
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic          tick_r;
   logic          tick_nxt;

   // Count half periods while running, restart when stopped
   always_comb begin
      count_nxt = '0;
      tick_nxt  = 1'b0;
      if (run) begin
         if (count_r == halfCount - CW'(1)) begin
            tick_nxt = 1'b1;
         end else begin
            count_nxt = count_r + CW'(1);
         end
      end
   end

   // Registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= '0;
         tick_r  <= 1'b0;
      end else begin
         count_r <= count_nxt;
         tick_r  <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule

/* File: rtl/spi_select_and_control.sv */
/*
 Serial port control and select logic: APB registers, master clock
 generation, byte shifter, slave select handling and mode fault.
 Assumes an APB master on the clock, and raw SPI pins whose wire levels
 are resolved outside from the active low output enables.
*/
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "spi_ctl_defines.svh"
module spi_select_and_control (
   input  wire logic        clock,       // System clock, 200 MHz
   input  wire logic        sys_rst,     // Async reset, active high
   input  wire logic [7:0]  paddr,       // APB address
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [31:0] pwdata,      // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error, unmapped address
   input  wire logic        globalIrqEn, // Core global interrupt enable
   input  wire logic        irqAck,      // Interrupt vector taken, pulse
   input  wire logic        sckIn,       // SCK pin level
   output logic             sckOut,      // SCK drive value
   output logic             sckOe_n,     // SCK drive enable, low drives
   input  wire logic        mosiIn,      // MOSI pin level
   output logic             mosiOut,     // MOSI drive value
   output logic             mosiOe_n,    // MOSI drive enable, low drives
   input  wire logic        misoIn,      // MISO pin level
   output logic             misoOut,     // MISO drive value
   output logic             misoOe_n,    // MISO drive enable, low drives
   input  wire logic        ssIn,        // Select pin level
   output logic             ssOut,       // Select drive value
   output logic             ssOe_n,      // Select drive enable, low drives
   output logic             irq          // Interrupt request
);
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [4:0]  pinCfg_r, pinCfg_nxt;
   logic        dblRate_r, dblRate_nxt;
   logic        doneFlag_r, doneFlag_nxt;
   logic        collFlag_r, collFlag_nxt;
   logic        stsSeen_r, stsSeen_nxt;
   logic [7:0]  txShift_r, txShift_nxt;
   logic [7:0]  rxShift_r, rxShift_nxt;
   logic [7:0]  rxBuf_r, rxBuf_nxt;
   logic [3:0]  sampleCnt_r, sampleCnt_nxt;
   logic [3:0]  edgeCnt_r, edgeCnt_nxt;
   logic        sckLevel_r, sckLevel_nxt;
   logic        sckPrev_r, ssPrev_r;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic        sckOut_r, sckOut_nxt, sckOe_n_r, sckOe_n_nxt;
   logic        mosiOut_r, mosiOut_nxt, mosiOe_n_r, mosiOe_n_nxt;
   logic        misoOut_r, misoOut_nxt, misoOe_n_r, misoOe_n_nxt;
   logic        ssOut_r, ssOut_nxt, ssOe_n_r, ssOe_n_nxt;
   logic        irq_r, irq_nxt;
   spi_ctl_pkg::master_state_t mstState_r, mstState_nxt;

   logic       ssSync, sckSync, mosiSync, misoSync;
   logic       tick;
   logic [6:0] halfCount;
   logic       enabled, isMaster, clock_idle_level, clock_sample_phase, lsbFirst;
   logic       modeFault, slaveActive, ssRise, busy;
   logic       apbAccess, wrEn, rdEn, dataWr, dataAcc, startXfer;
   logic       edgeEv, levelAfter, sampleEv, setupEv, inBit, byteDone;
   logic [7:0] rxIn;

   // Pin synchronisers
   pin_sync #(.RESET_VAL(1'b1)) u_ssSync (
      .clock(clock), .sys_rst(sys_rst), .pinIn(ssIn), .levelOut(ssSync));
   pin_sync #(.RESET_VAL(1'b0)) u_sckSync (
      .clock(clock), .sys_rst(sys_rst), .pinIn(sckIn), .levelOut(sckSync));
   pin_sync #(.RESET_VAL(1'b0)) u_mosiSync (
      .clock(clock), .sys_rst(sys_rst), .pinIn(mosiIn), .levelOut(mosiSync));
   pin_sync #(.RESET_VAL(1'b0)) u_misoSync (
      .clock(clock), .sys_rst(sys_rst), .pinIn(misoIn), .levelOut(misoSync));

   // Master SCK rate, used only in master state
   always_comb begin
      case ({dblRate_r, ctrl_r[1:0]})
         3'b000:  halfCount = `HALF_DIV4;
         3'b001:  halfCount = `HALF_DIV16;
         3'b010:  halfCount = `HALF_DIV64;
         3'b011:  halfCount = `HALF_DIV128;
         3'b100:  halfCount = `HALF_DIV2;
         3'b101:  halfCount = `HALF_DIV8;
         3'b110:  halfCount = `HALF_DIV32;
         default: halfCount = `HALF_DIV64;
      endcase
   end

   sck_divider #(.CW(7)) u_div (
      .clock(clock), .sys_rst(sys_rst),
      .run(mstState_r == spi_ctl_pkg::MS_SHIFT),
      .halfCount(halfCount), .tick(tick));

   // Mode decode and select handling
   assign enabled     = ctrl_r[`CTL_EN];
   assign isMaster    = enabled & ctrl_r[`CTL_MASTER_SELECT];
   assign clock_idle_level        = ctrl_r[`CTL_CLOCK_IDLE_LEVEL];
   assign clock_sample_phase        = ctrl_r[`CTL_CLOCK_SAMPLE_PHASE];
   assign lsbFirst    = ctrl_r[`CTL_ORDER];
   assign modeFault   = isMaster & ~pinCfg_r[`PIN_DIR_SS] & ~ssSync;
   assign slaveActive = enabled & ~ctrl_r[`CTL_MASTER_SELECT] & ~ssSync;
   assign ssRise      = ssSync & ~ssPrev_r;
   assign busy        = (mstState_r == spi_ctl_pkg::MS_SHIFT) |
                        (slaveActive & (sampleCnt_r != 4'h0));

   // APB decode; effects happen at the access edge
   assign apbAccess = psel & penable & pready_r;
   assign wrEn      = apbAccess & pwrite;
   assign rdEn      = apbAccess & ~pwrite;
   assign dataAcc   = apbAccess & (paddr == `OFF_DATA);
   assign dataWr    = dataAcc & pwrite;
   assign startXfer = dataWr & isMaster & ~busy & ~modeFault;

   // SCK edge events from the generator or from the pin
   always_comb begin
      edgeEv     = 1'b0;
      levelAfter = sckSync;
      if (isMaster) begin
         edgeEv     = (mstState_r == spi_ctl_pkg::MS_SHIFT) & tick;
         levelAfter = ~sckLevel_r;
      end else if (slaveActive) begin
         edgeEv = sckSync ^ sckPrev_r;
      end
      sampleEv = edgeEv & ((levelAfter != clock_idle_level) ^ clock_sample_phase);
      setupEv  = edgeEv & ~((levelAfter != clock_idle_level) ^ clock_sample_phase);
   end

   assign inBit = isMaster ? misoSync : mosiSync;
   assign rxIn  = lsbFirst ? {inBit, rxShift_r[7:1]} : {rxShift_r[6:0], inBit};

   // Byte shifter
   always_comb begin
      txShift_nxt   = txShift_r;
      rxShift_nxt   = rxShift_r;
      rxBuf_nxt     = rxBuf_r;
      sampleCnt_nxt = sampleCnt_r;
      byteDone      = 1'b0;
      if (dataWr && !busy) begin
         txShift_nxt = pwdata[7:0];
      end else if (setupEv && !(clock_sample_phase && sampleCnt_r == 4'h0)) begin
         txShift_nxt = lsbFirst ? {1'b0, txShift_r[7:1]} : {txShift_r[6:0], 1'b0};
      end
      if (sampleEv) begin
         rxShift_nxt   = rxIn;
         sampleCnt_nxt = sampleCnt_r + 4'h1;
         if (sampleCnt_r == `LAST_BIT) begin
            rxBuf_nxt     = rxIn;
            sampleCnt_nxt = 4'h0;
            byteDone      = 1'b1;
         end
      end
      if ((ssRise && !ctrl_r[`CTL_MASTER_SELECT]) || !enabled || modeFault) begin
         rxShift_nxt   = 8'h00;
         sampleCnt_nxt = 4'h0;
      end
   end

   // Master clock generator state
   always_comb begin
      mstState_nxt = mstState_r;
      edgeCnt_nxt  = edgeCnt_r;
      sckLevel_nxt = sckLevel_r;
      case (mstState_r)
         spi_ctl_pkg::MS_IDLE: begin
            sckLevel_nxt = clock_idle_level;
            edgeCnt_nxt  = 4'h0;
            if (startXfer) begin
               mstState_nxt = spi_ctl_pkg::MS_SHIFT;
            end
         end
         spi_ctl_pkg::MS_SHIFT: begin
            if (modeFault || !isMaster) begin
               mstState_nxt = spi_ctl_pkg::MS_IDLE;
            end else if (tick) begin
               sckLevel_nxt = ~sckLevel_r;
               edgeCnt_nxt  = edgeCnt_r + 4'h1;
               if (edgeCnt_r == `LAST_EDGE) begin
                  mstState_nxt = spi_ctl_pkg::MS_IDLE;
               end
            end
         end
         default: mstState_nxt = spi_ctl_pkg::MS_IDLE;
      endcase
   end

   // Software registers and flags; hardware set wins over clear
   always_comb begin
      ctrl_nxt    = ctrl_r;
      pinCfg_nxt  = pinCfg_r;
      dblRate_nxt = dblRate_r;
      stsSeen_nxt = stsSeen_r;
      if (wrEn && paddr == `OFF_CTRL) begin
         ctrl_nxt = pwdata[7:0];
      end
      if (wrEn && paddr == `OFF_STATUS) begin
         dblRate_nxt = pwdata[`STS_DBL];
      end
      if (wrEn && paddr == `OFF_PINCFG) begin
         pinCfg_nxt = pwdata[4:0];
      end
      if (modeFault) begin
         ctrl_nxt[`CTL_MASTER_SELECT] = 1'b0;
      end
      if (dataAcc) begin
         stsSeen_nxt = 1'b0;
      end else if (rdEn && paddr == `OFF_STATUS && (doneFlag_r || collFlag_r)) begin
         stsSeen_nxt = 1'b1;
      end
      doneFlag_nxt = byteDone | modeFault |
                     (doneFlag_r & ~(irqAck | (dataAcc & stsSeen_r)));
      collFlag_nxt = (dataWr & busy) | (collFlag_r & ~(dataAcc & stsSeen_r));
   end

   // APB answer: ready and data one cycle after setup
   always_comb begin
      pready_nxt  = psel & ~penable;
      pslverr_nxt = 1'b0;
      prdata_nxt  = 32'h0000_0000;
      if (psel && !penable) begin
         case (paddr)
            `OFF_CTRL:   prdata_nxt = {24'h00_0000, ctrl_r};
            `OFF_STATUS: prdata_nxt = {24'h00_0000, doneFlag_r, collFlag_r, 5'h00, dblRate_r};
            `OFF_DATA:   prdata_nxt = {24'h00_0000, rxBuf_r};
            `OFF_PINCFG: prdata_nxt = {27'h000_0000, pinCfg_r};
            default:     pslverr_nxt = 1'b1;
         endcase
      end
   end

   // Pin drive; active low enables
   always_comb begin
      sckOut_nxt   = (mstState_r == spi_ctl_pkg::MS_SHIFT) ? sckLevel_r : clock_idle_level;
      sckOe_n_nxt  = ~(isMaster & pinCfg_r[`PIN_DIR_SCK]);
      mosiOut_nxt  = lsbFirst ? txShift_r[0] : txShift_r[7];
      mosiOe_n_nxt = ~(isMaster & pinCfg_r[`PIN_DIR_MOSI]);
      misoOut_nxt  = mosiOut_nxt;
      misoOe_n_nxt = ~(slaveActive & pinCfg_r[`PIN_DIR_MISO]);
      ssOut_nxt    = pinCfg_r[`PIN_SS_VAL];
      ssOe_n_nxt   = ~((~enabled | isMaster) & pinCfg_r[`PIN_DIR_SS]);
      irq_nxt      = ctrl_r[`CTL_IRQEN] & doneFlag_r & globalIrqEn;
   end

   // All registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r      <= `RST_CTRL;
         pinCfg_r    <= `RST_PINCFG;
         dblRate_r   <= 1'b0;
         doneFlag_r  <= 1'b0;
         collFlag_r  <= 1'b0;
         stsSeen_r   <= 1'b0;
         txShift_r   <= 8'h00;
         rxShift_r   <= 8'h00;
         rxBuf_r     <= 8'h00;
         sampleCnt_r <= 4'h0;
         edgeCnt_r   <= 4'h0;
         sckLevel_r  <= 1'b0;
         sckPrev_r   <= 1'b0;
         ssPrev_r    <= 1'b1;
         mstState_r  <= spi_ctl_pkg::MS_IDLE;
         prdata_r    <= 32'h0000_0000;
         pready_r    <= 1'b0;
         pslverr_r   <= 1'b0;
         sckOut_r    <= 1'b0;
         sckOe_n_r   <= 1'b1;
         mosiOut_r   <= 1'b0;
         mosiOe_n_r  <= 1'b1;
         misoOut_r   <= 1'b0;
         misoOe_n_r  <= 1'b1;
         ssOut_r     <= 1'b0;
         ssOe_n_r    <= 1'b1;
         irq_r       <= 1'b0;
      end else begin
         ctrl_r      <= ctrl_nxt;
         pinCfg_r    <= pinCfg_nxt;
         dblRate_r   <= dblRate_nxt;
         doneFlag_r  <= doneFlag_nxt;
         collFlag_r  <= collFlag_nxt;
         stsSeen_r   <= stsSeen_nxt;
         txShift_r   <= txShift_nxt;
         rxShift_r   <= rxShift_nxt;
         rxBuf_r     <= rxBuf_nxt;
         sampleCnt_r <= sampleCnt_nxt;
         edgeCnt_r   <= edgeCnt_nxt;
         sckLevel_r  <= sckLevel_nxt;
         sckPrev_r   <= sckSync;
         ssPrev_r    <= ssSync;
         mstState_r  <= mstState_nxt;
         prdata_r    <= prdata_nxt;
         pready_r    <= pready_nxt;
         pslverr_r   <= pslverr_nxt;
         sckOut_r    <= sckOut_nxt;
         sckOe_n_r   <= sckOe_n_nxt;
         mosiOut_r   <= mosiOut_nxt;
         mosiOe_n_r  <= mosiOe_n_nxt;
         misoOut_r   <= misoOut_nxt;
         misoOe_n_r  <= misoOe_n_nxt;
         ssOut_r     <= ssOut_nxt;
         ssOe_n_r    <= ssOe_n_nxt;
         irq_r       <= irq_nxt;
      end
   end

   assign prdata   = prdata_r;
   assign pready   = pready_r;
   assign pslverr  = pslverr_r;
   assign sckOut   = sckOut_r;
   assign sckOe_n  = sckOe_n_r;
   assign mosiOut  = mosiOut_r;
   assign mosiOe_n = mosiOe_n_r;
   assign misoOut  = misoOut_r;
   assign misoOe_n = misoOe_n_r;
   assign ssOut    = ssOut_r;
   assign ssOe_n   = ssOe_n_r;
   assign irq      = irq_r;

   // Checks on select handling, flags and transfers
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_slaveSsIn;
      enabled && !ctrl_r[`CTL_MASTER_SELECT] |=> ssOe_n_r;
   endproperty
   a_slaveSsIn: assert property (p_slaveSsIn) else $error("select driven in slave");

   property p_passive;
      enabled && !ctrl_r[`CTL_MASTER_SELECT] && ssSync |=> mosiOe_n_r && misoOe_n_r && sckOe_n_r;
   endproperty
   a_passive: assert property (p_passive) else $error("pin driven while deselected");

   property p_ssReset;
      ssRise && !ctrl_r[`CTL_MASTER_SELECT] |=> sampleCnt_r == 4'h0 && rxShift_r == 8'h00;
   endproperty
   a_ssReset: assert property (p_ssReset) else $error("shifter not reset on select");

   property p_faultClr;
      modeFault |=> !ctrl_r[`CTL_MASTER_SELECT] && mstState_r == spi_ctl_pkg::MS_IDLE;
   endproperty
   a_faultClr: assert property (p_faultClr) else $error("master kept after fault");

   property p_faultPins;
      modeFault |=> ##1 sckOe_n_r && mosiOe_n_r;
   endproperty
   a_faultPins: assert property (p_faultPins) else $error("pins driven after fault");

   property p_faultFlag;
      modeFault |=> doneFlag_r;
   endproperty
   a_faultFlag: assert property (p_faultFlag) else $error("done not set on fault");

   property p_noRestore;
      !ctrl_r[`CTL_MASTER_SELECT] && !(wrEn && paddr == `OFF_CTRL) |=> !ctrl_r[`CTL_MASTER_SELECT];
   endproperty
   a_noRestore: assert property (p_noRestore) else $error("master restored by hardware");

   property p_irq;
      doneFlag_r && ctrl_r[`CTL_IRQEN] && globalIrqEn |=> irq_r;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   property p_disabled;
      !enabled |=> mstState_r == spi_ctl_pkg::MS_IDLE && sckOe_n_r;
   endproperty
   a_disabled: assert property (p_disabled) else $error("activity while disabled");

   property p_byteEnd;
      mstState_r == spi_ctl_pkg::MS_SHIFT && tick && edgeCnt_r == `LAST_EDGE && isMaster
         && !modeFault |=> mstState_r == spi_ctl_pkg::MS_IDLE ##1 sckOut_r == clock_idle_level; // Pin lags one cycle
   endproperty
   a_byteEnd: assert property (p_byteEnd) else $error("clock not stopped after byte");
endmodule

/* File: testbench/spi_slave_model.sv */
/*
 Behavioural serial slave facing the block's master side.
 Assumes the bench gives it the wire levels and the frame select.
*/
`timescale 1ns/1ps
module spi_slave_model (
   input  wire logic       clock,    // Bench clock for gap timing
   input  wire logic       selN,     // Frame select, active low
   input  wire logic       sck,      // Serial clock wire
   input  wire logic       mosi,     // Data from master
   input  wire logic       clock_idle_level,     // Idle level
   input  wire logic       clock_sample_phase,     // Sample phase
   input  wire logic       lsbFirst, // Bit order
   input  wire logic [7:0] txByte,   // Byte to return
   output logic            miso,     // Data to master
   output logic      [7:0] rxByte,   // Byte received
   output int              halfCyc   // First half period in cycles
);
   int cyc = 0;
   int last = 0;
   int edges = 0;
   int idx = 0;
   // Cycle count; released line toggles so it never looks held
   always @(posedge clock) begin
      cyc++;
      if (selN) miso = ~miso;
   end
   // Frame start presents the first bit
   always @(negedge selN) begin
      edges = 0;
      idx = 0;
      rxByte = 8'h00;
      miso = lsbFirst ? txByte[0] : txByte[7];
   end
   // Leading edge leaves idle; sample or set up by phase
   always @(sck) if (!selN) begin
      edges++;
      if (edges == 2) halfCyc = cyc - last;
      last = cyc;
      if ((sck != clock_idle_level) != clock_sample_phase) begin
         rxByte[lsbFirst ? idx : 7 - idx] = mosi;
         idx++;
      end else if (idx < 8) begin
         miso = lsbFirst ? txByte[idx] : txByte[7 - idx];
      end
   end
endmodule

/* File: testbench/tb_spi_select_and_control.sv */
/*
 Self-checking bench: registers, master transfers in all modes and rates,
 mode fault. Assumes the slave model and the block's define header.
*/
`timescale 1ns/1ps
`include "spi_ctl_defines.svh"
module tb_spi_select_and_control;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
   logic        pready, pslverr, irq, sckOut, sckOe_n, mosiOut, mosiOe_n;
   logic        misoOut, misoOe_n, ssOut, ssOe_n, miso, err, sckW;
   logic        globalIrqEn = 1'b1, irqAck = 1'b0, selN = 1'b1;
   logic        ssLvl = 1'b1;
   logic        sckB = 1'b0, mosiB = 1'b1; // Bench as far master in slave tests
   logic        clock_idle_level = 1'b0, clock_sample_phase = 1'b0, ord = 1'b0;
   logic [7:0]  txSlave = 8'h00, rxSlave, txByte;
   logic [31:0] rnd = 32'h0000_035c;
   int          halfCyc, bad_count = 0, checked = 0;
   // Wire levels from drive enables
   assign sckW = sckOe_n ? sckB : sckOut;
   spi_select_and_control uut (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .globalIrqEn(globalIrqEn), .irqAck(irqAck), .sckIn(sckW),
      .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiOe_n ? mosiB : mosiOut), .mosiOut(mosiOut),
      .mosiOe_n(mosiOe_n), .misoIn(misoOe_n ? miso : misoOut), .misoOut(misoOut),
      .misoOe_n(misoOe_n), .ssIn(ssOe_n ? ssLvl : ssOut), .ssOut(ssOut), .ssOe_n(ssOe_n), .irq(irq));
   spi_slave_model slave (.clock(clock), .selN(selN), .sck(sckW), .mosi(mosiOe_n ? mosiB : mosiOut),
      .clock_idle_level(clock_idle_level), .clock_sample_phase(clock_sample_phase), .lsbFirst(ord), .txByte(txSlave), .miso(miso), .rxByte(rxSlave),
      .halfCyc(halfCyc));
   // Clock
   initial forever #2.5 clock = ~clock;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic int halfOf(input logic [2:0] c);
      int d [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
      return d[c] / 2;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic waitDone();
      int n;
      n = 0;
      do begin
         apb(1'b0, `OFF_STATUS, 8'h00);
         n++;
      end while (rd[7] !== 1'b1 && n < 600);
      if (n >= 600) bad_count++;
   endtask
   // Far master: n bits of v, MSB first, mode 0; optionally checks the returned bits of t
   task automatic slaveBits(input logic [7:0] v, input int n, input logic [7:0] t, input logic c);
      for (int b = 7; b > 7 - n; b--) begin
         mosiB <= v[b];
         repeat (8) @(posedge clock);
         if (c) chk(misoOut, t[b]);
         sckB <= 1'b1;
         repeat (8) @(posedge clock);
         sckB <= 1'b0;
      end
      repeat (8) @(posedge clock);
   endtask
   task automatic conclude();
      $display("Counts: %0d compared, %0d mismatched", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #400_000;
      bad_count++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      apb(1'b0, `OFF_CTRL, 8'h00);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h10, 8'h00);
      chk(err, 1'b1);
      apb(1'b1, `OFF_PINCFG, 8'h05);
      $display("test registers done");
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         txByte = rnd[7:0];
         txSlave <= rnd[15:8];
         ord <= k[0];
         clock_idle_level <= k[1];
         clock_sample_phase <= k[2];
         apb(1'b1, `OFF_CTRL, {2'b11, k[0], 1'b1, k[1], k[2], 2'b11});
         repeat (2) @(posedge clock);
         selN <= 1'b0;
         apb(1'b1, `OFF_DATA, txByte);
         waitDone();
         repeat (140) @(posedge clock);
         chk(rxSlave, txByte);
         chk(irq, 1'b1);
         chk(sckOut, clock_idle_level);
         apb(1'b0, `OFF_DATA, 8'h00);
         chk(rd, {24'h00_0000, txSlave});
         apb(1'b0, `OFF_STATUS, 8'h00);
         chk(rd[7], 1'b0);
         selN <= 1'b1;
      end
      $display("test modes done");
      ord <= 1'b0;
      clock_idle_level <= 1'b0;
      clock_sample_phase <= 1'b0;
      for (int r = 0; r < 8; r++) begin
         apb(1'b1, `OFF_STATUS, {7'h00, r[2]});
         apb(1'b1, `OFF_CTRL, {6'h14, r[1:0]});
         repeat (2) @(posedge clock);
         selN <= 1'b0;
         rnd = lfsr(rnd);
         apb(1'b1, `OFF_DATA, rnd[7:0]);
         waitDone();
         chk(halfCyc, halfOf(r[2:0]));
         chk(irq, 1'b0);
         repeat (140) @(posedge clock);
         apb(1'b0, `OFF_DATA, 8'h00);
         selN <= 1'b1;
      end
      $display("test rates done");
      apb(1'b1, `OFF_CTRL, 8'hd0);
      ssLvl <= 1'b0;
      repeat (12) @(posedge clock);
      chk(sckOe_n, 1'b1);
      chk(mosiOe_n, 1'b1);
      chk(ssOe_n, 1'b1);
      chk(irq, 1'b1);
      globalIrqEn <= 1'b0;
      repeat (3) @(posedge clock);
      chk(irq, 1'b0);
      globalIrqEn <= 1'b1;
      apb(1'b0, `OFF_CTRL, 8'h00);
      chk(rd, 32'h0000_00c0);
      irqAck <= 1'b1;
      @(posedge clock);
      irqAck <= 1'b0;
      repeat (3) @(posedge clock);
      chk(irq, 1'b0);
      ssLvl <= 1'b1;
      repeat (12) @(posedge clock);
      apb(1'b0, `OFF_CTRL, 8'h00);
      chk(rd, 32'h0000_00c0);
      apb(1'b1, `OFF_PINCFG, 8'h07);
      rnd = lfsr(rnd);
      apb(1'b1, `OFF_DATA, rnd[7:0]);
      ssLvl <= 1'b0;
      repeat (8) @(posedge clock);
      chk(misoOe_n, 1'b0);
      chk(mosiOe_n & sckOe_n & ssOe_n, 1'b1);
      slaveBits(rnd[15:8], 8, rnd[7:0], 1'b1);
      apb(1'b0, `OFF_STATUS, 8'h00);
      chk(rd[7], 1'b1);
      apb(1'b0, `OFF_DATA, 8'h00);
      chk(rd, {24'h00_0000, rnd[15:8]});
      slaveBits(rnd[23:16], 3, 8'h00, 1'b0);
      ssLvl <= 1'b1;
      repeat (8) @(posedge clock);
      chk(misoOe_n, 1'b1);
      slaveBits(~rnd[23:16], 3, 8'h00, 1'b0);
      ssLvl <= 1'b0;
      repeat (8) @(posedge clock);
      slaveBits(rnd[31:24], 8, 8'h00, 1'b0);
      apb(1'b0, `OFF_STATUS, 8'h00);
      apb(1'b0, `OFF_DATA, 8'h00);
      chk(rd, {24'h00_0000, rnd[31:24]});
      ssLvl <= 1'b1;
      repeat (8) @(posedge clock);
      $display("test slave done");
      apb(1'b1, `OFF_CTRL, 8'h90);
      repeat (4) @(posedge clock);
      chk(sckOe_n, 1'b1);
      chk(mosiOe_n, 1'b1);
      chk(misoOe_n, 1'b1);
      apb(1'b1, `OFF_PINCFG, 8'h0f);
      apb(1'b1, `OFF_CTRL, 8'h50);
      repeat (8) @(posedge clock);
      chk(ssOe_n, 1'b0);
      chk(ssOut, 1'b0);
      apb(1'b0, `OFF_CTRL, 8'h00);
      chk(rd, 32'h0000_0050);
      $display("test enable and select output done");
      conclude();
   end
endmodule
